/* design/twi_slave_pkg.sv */
// constants and carrier types of the two-wire register slave
package twi_slave_pkg;
  localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h10;
  localparam logic [6:0] SLAVE_ADDR_ALTERNATE = 7'h18;
  localparam logic [15:0] POINTER_RESET = 16'h0000;
  localparam int BITS_PER_BYTE = 8;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam int DATA_HOLD_NS = 300;
  localparam int SYS_CLK_NS = 50;
  localparam int HOLD_CYCLES = (DATA_HOLD_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SLAVE_ADDRESS_SELECT = 3'b001,
    ST_ADDRH = 3'b011,
    ST_ADDRL = 3'b010,
    ST_WDATA = 3'b110,
    ST_RDATA = 3'b111,
    ST_WAIT  = 3'b101
  } state_type;

  typedef struct packed {
    logic        write_en;
    logic        read_en;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } reg_req_type;
endpackage : twi_slave_pkg

/* design/twi_sync.sv */
// two-flop synchroniser for the serial clock and data pins
`timescale 1ns/1ps
module twi_sync (
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic [1:0] async_in,
  output logic      [1:0] sync_out
);
  logic [1:0] meta_q;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta_q   <= 2'h3;
      sync_out <= 2'h3;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : twi_sync

/* design/two_wire_register_slave_sequencer.sv */
// slave-side transaction sequencer of the two-wire register port
`timescale 1ns/1ps
module two_wire_register_slave_sequencer
  import twi_slave_pkg::*;
(
  input  wire logic                       sys_clk,
  input  wire logic                       srst,
  input  wire logic                       serial_clock,
  input  wire logic                       serial_data_in,
  output logic                            serial_data_out,
  output logic                            serial_data_oe,
  input  wire logic                       slave_address_select_en,
  input  wire logic                       slave_address_select,
  output twi_slave_pkg::reg_req_type      reg_req,
  input  wire logic [7:0]                 reg_rdata,
  output logic [15:0]                     pointer
);
  import twi_slave_pkg::*;

  ////////////////////////////////////////////////////////////////
  logic [1:0] pins_s;
  logic       scl_q;
  logic       sda_q;
  twi_sync u_sync (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .async_in ({serial_clock, serial_data_in}),
    .sync_out (pins_s)
  );
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= pins_s[1];
      sda_q <= pins_s[0];
    end
  end
  wire scl      = pins_s[1];
  wire sda      = pins_s[0];
  wire scl_rise = scl & ~scl_q;
  wire scl_fall = ~scl & scl_q;
  wire start_ev = scl & scl_q & sda_q & ~sda;
  wire stop_ev  = scl & scl_q & ~sda_q & sda;

  // the address straps are pins as well and cross on two flops like the bus
  logic [1:0] sel_m_q;
  logic [1:0] sel_s_q;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sel_m_q <= 2'h0;
      sel_s_q <= 2'h0;
    end else begin
      sel_m_q <= {slave_address_select_en, slave_address_select};
      sel_s_q <= sel_m_q;
    end
  end

  ////////////////////////////////////////////////////////////////
  state_type   state_q;
  state_type   state_d;
  logic [3:0]  bit_cnt_q;
  logic [7:0]  shift_q;
  logic [15:0] ptr_q;
  logic        ack_drive_q;
  logic        tx_q;
  logic        oe_q;
  logic [3:0]  hold_q;
  logic        seen_rise_q;
  logic        rd_pend_q;
  logic        nack_q;
  reg_req_type req_q;

  // nine slots per byte: eight data bits then the acknowledge
  // the fall that follows a start ends no bit, so counting waits for a rise
  wire        byte_done = scl_fall & seen_rise_q & (bit_cnt_q == 4'(BITS_PER_BYTE - 1));
  wire        ack_rise  = scl_rise & (bit_cnt_q == ACK_SLOT);
  wire        ack_end   = scl_fall & (bit_cnt_q == ACK_SLOT);
  wire [7:0]  rx_byte   = {shift_q[6:0], sda};
  wire        use_alt   = sel_s_q[1] & sel_s_q[0];
  wire [6:0]  my_addr   = use_alt ? SLAVE_ADDR_ALTERNATE : SLAVE_ADDR_DEFAULT;
  // at the closing fall the whole address byte already sits in the shifter
  wire        addr_hit  = shift_q[7:1] == my_addr;

  ////////////////////////////////////////////////////////////////
  always_comb begin
    state_d = state_q;
    if (start_ev) begin
      state_d = ST_SLAVE_ADDRESS_SELECT;
    end else if (stop_ev) begin
      state_d = ST_IDLE;
    end else if (ack_end) begin
      unique case (state_q)
        ST_SLAVE_ADDRESS_SELECT: state_d = !ack_drive_q ? ST_WAIT : (tx_q ? ST_RDATA : ST_ADDRH);
        ST_ADDRH: state_d = ST_ADDRL;
        ST_ADDRL: state_d = ST_WDATA;
        ST_WDATA: state_d = ST_WDATA;
        ST_RDATA: state_d = nack_q ? ST_WAIT : ST_RDATA;
        ST_IDLE:  state_d = ST_IDLE;
        ST_WAIT:  state_d = ST_WAIT;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_q     <= ST_IDLE;
      bit_cnt_q   <= 4'h0;
      shift_q     <= 8'h00;
      ptr_q       <= POINTER_RESET;
      ack_drive_q <= 1'b0;
      tx_q        <= 1'b0;
      nack_q      <= 1'b0;
      seen_rise_q <= 1'b0;
      req_q       <= '0;
    end else begin
      state_q       <= state_d;
      req_q.write_en <= 1'b0;
      req_q.read_en  <= 1'b0;
      if (start_ev || stop_ev) begin
        bit_cnt_q   <= 4'h0;
        ack_drive_q <= 1'b0;
        tx_q        <= 1'b0;
        seen_rise_q <= 1'b0;
      end else if (scl_rise) begin
        shift_q     <= rx_byte;
        seen_rise_q <= 1'b1;
        if (ack_rise && state_q == ST_RDATA) nack_q <= sda;
      end else if (scl_fall && seen_rise_q && state_q != ST_IDLE && state_q != ST_WAIT) begin
        bit_cnt_q <= (bit_cnt_q == ACK_SLOT) ? 4'h0 : bit_cnt_q + 4'h1;
        if (byte_done) begin
          unique case (state_q)
            ST_SLAVE_ADDRESS_SELECT: begin
              ack_drive_q <= addr_hit;
              tx_q        <= addr_hit & shift_q[0];
            end
            ST_ADDRH: ptr_q[15:8] <= shift_q;
            ST_ADDRL: ptr_q[7:0]  <= shift_q;
            ST_WDATA: begin
              req_q.write_en <= 1'b1;
              req_q.addr     <= ptr_q;
              req_q.wdata    <= shift_q;
              ptr_q          <= ptr_q + 16'h0001;
            end
            ST_RDATA: ptr_q <= ptr_q + 16'h0001;
            default: ;
          endcase
        end
        if (bit_cnt_q == ACK_SLOT && state_q == ST_SLAVE_ADDRESS_SELECT && !ack_drive_q) begin
          ack_drive_q <= 1'b0;
        end
      end
      // fetch next read byte at the end of each acknowledge slot that leaves the sequencer in ST_RDATA
      if (ack_end && state_d == ST_RDATA) begin
        req_q.read_en <= 1'b1;
        req_q.addr    <= ptr_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // data line changes after a hold delay past the falling clock; a start or stop releases it at once
  logic [7:0] tx_shift_q;
  wire        tx_bit    = tx_shift_q[3'h7 - bit_cnt_q[2:0]];
  wire        ack_owned = bit_cnt_q == ACK_SLOT && state_q != ST_RDATA && state_q != ST_IDLE
                          && state_q != ST_WAIT && (state_q != ST_SLAVE_ADDRESS_SELECT || ack_drive_q);
  logic drive_now;
  always_comb begin
    drive_now = 1'b0;
    if (state_q == ST_RDATA && bit_cnt_q != ACK_SLOT) begin
      drive_now = ~tx_bit;
    end else if (ack_owned) begin
      drive_now = 1'b1;
    end
  end

  // the store answers one cycle after the fetch pulse, so the shifter loads then
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tx_shift_q <= 8'hFF;
      rd_pend_q  <= 1'b0;
      hold_q     <= 4'h0;
      oe_q       <= 1'b0;
    end else if (start_ev || stop_ev) begin
      rd_pend_q <= 1'b0;
      hold_q    <= 4'h0;
      oe_q      <= 1'b0;
    end else begin
      rd_pend_q <= req_q.read_en;
      if (rd_pend_q) tx_shift_q <= reg_rdata;
      if (scl_fall) hold_q <= 4'(HOLD_CYCLES);
      else if (hold_q != 4'h0) hold_q <= hold_q - 4'h1;
      if (hold_q == 4'h1) oe_q <= drive_now;
    end
  end

  assign serial_data_out = 1'b0;
  assign serial_data_oe  = oe_q;
  assign reg_req         = req_q;
  assign pointer         = ptr_q;

  ////////////////////////////////////////////////////////////////
  sequence stop_seen_s;
    stop_ev;
  endsequence
  sequence released_s;
    !serial_data_oe [*2];
  endsequence

  stop_release_a: assert property (@(posedge sys_clk) disable iff (srst)
    stop_seen_s |=> released_s) else $error("line not released after stop");
  stop_idle_a: assert property (@(posedge sys_clk) disable iff (srst)
    stop_ev && !start_ev |=> state_q == ST_IDLE) else $error("no idle after stop");
  stop_ptr_a: assert property (@(posedge sys_clk) disable iff (srst)
    stop_ev |=> $stable(ptr_q)) else $error("pointer lost on stop");
  miss_quiet_a: assert property (@(posedge sys_clk) disable iff (srst)
    state_q == ST_WAIT |-> !serial_data_oe) else $error("drove line when unaddressed");
  ptr_step_a: assert property (@(posedge sys_clk) disable iff (srst)
    req_q.write_en |-> ptr_q == req_q.addr + 16'h0001) else $error("pointer not advanced");
  wr_addr_a: assert property (@(posedge sys_clk) disable iff (srst)
    req_q.write_en |-> $past(state_q) == ST_WDATA) else $error("write outside data phase");
  hi_first_a: assert property (@(posedge sys_clk) disable iff (srst)
    byte_done && state_q == ST_ADDRH |=> ptr_q[15:8] == $past(shift_q))
    else $error("high address byte not loaded first");
  addr_sel_a: assert property (@(posedge sys_clk) disable iff (srst)
    $rose(ack_drive_q) |-> ($past(shift_q) >> 1)
      == {1'b0, ($past(use_alt) ? SLAVE_ADDR_ALTERNATE : SLAVE_ADDR_DEFAULT)})
    else $error("acknowledged a foreign address");
  oe_idle_a: assert property (@(posedge sys_clk) disable iff (srst)
    state_q == ST_IDLE |=> !serial_data_oe || $past(state_q) != ST_IDLE)
    else $error("drive while idle");
endmodule : two_wire_register_slave_sequencer

/* sim/twi_master_model.sv */
// bus master model that drives the serial clock and data line
`timescale 1ns/1ps
module twi_master_model (
  input  wire logic sys_clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_drv
);
  // low phase is long: the slave changes data about nine cycles after a fall
  localparam int LOW_CYC  = 12;
  localparam int HIGH_CYC = 8;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  // data moves only while the clock is low; s is sampled mid high phase
  task automatic xfer(input logic b, output logic s);
    scl <= 1'b0;
    tick(3);
    sda_drv <= b;
    tick(LOW_CYC - 3);
    scl <= 1'b1;
    tick(HIGH_CYC / 2);
    s = sda;
    tick(HIGH_CYC / 2);
  endtask : xfer
  // (1,0) start or restart, (0,1) stop: data changes with the clock high
  task automatic cond(input logic a, input logic b);
    scl <= 1'b0;
    tick(3);
    sda_drv <= a;
    tick(LOW_CYC - 3);
    scl <= 1'b1;
    tick(HIGH_CYC / 2);
    sda_drv <= b;
    tick(HIGH_CYC / 2);
  endtask : cond
  task automatic wr(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) xfer(d[i], s);
    xfer(1'b1, s);
    ack = ~s;
  endtask : wr
  task automatic rd(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) xfer(1'b1, d[i]);
    xfer(~ack, s);
  endtask : rd
endmodule : twi_master_model

/* sim/two_wire_register_slave_sequencer_test.sv */
// self-checking bench of the two-wire register slave sequencer
`timescale 1ns/1ps
module two_wire_register_slave_sequencer_test;
  import twi_slave_pkg::*;
  logic        sys_clk = 1'b0;
  logic        srst    = 1'b1;
  logic        sel_en  = 1'b0;
  logic        sel     = 1'b0;
  logic [7:0]  reg_rdata = 8'h00;
  logic        scl, sda_drv, sdo, oe;
  wire logic   sda;
  reg_req_type reg_req;
  logic [15:0] pointer;
  logic [23:0] wq[$];
  int          num_errors = 0;
  int          n_tests = 0;
  // open drain with pull-up: low when either side pulls
  assign sda = sda_drv & ~oe;
  always #25 sys_clk = ~sys_clk;
  two_wire_register_slave_sequencer uut (.sys_clk(sys_clk), .srst(srst),
    .serial_clock(scl), .serial_data_in(sda), .serial_data_out(sdo),
    .serial_data_oe(oe), .slave_address_select_en(sel_en),
    .slave_address_select(sel), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .pointer(pointer));
  twi_master_model m (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_drv(sda_drv));
  function automatic logic [7:0] rval(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction : rval
  always @(posedge sys_clk) begin
    if (reg_req.read_en === 1'b1) reg_rdata <= rval(reg_req.addr);
    if (reg_req.write_en === 1'b1) wq.push_back({reg_req.addr, reg_req.wdata});
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wb(input logic [7:0] d, input logic a);
    logic s;
    m.wr(d, s);
    chk("ack", {23'h0, a}, {23'h0, s});
  endtask : wb
  task automatic rb(input logic a, input logic [15:0] adr);
    logic [7:0] d;
    m.rd(a, d);
    chk("rdata", {16'h0, rval(adr)}, {16'h0, d});
  endtask : rb
  task automatic ptr(input logic [15:0] e);
    chk("pointer", {8'h00, e}, {8'h00, pointer});
    chk("data out level", 24'h0, {23'h0, sdo});
  endtask : ptr
  ////////////////////////////////////////////////////////////////
  task automatic t_write();
    m.cond(1'b1, 1'b0);
    wb(8'h20, 1'b1);
    wb(8'h12, 1'b1);
    wb(8'h34, 1'b1);
    wb(8'hA1, 1'b1);
    wb(8'hB2, 1'b1);
    m.cond(1'b0, 1'b1);
    chk("write0", 24'h1234A1, wq.pop_front());
    chk("write1", 24'h1235B2, wq.pop_front());
    ptr(16'h1236);
  endtask : t_write
  task automatic t_read();
    m.cond(1'b1, 1'b0);
    wb(8'h20, 1'b1);
    wb(8'h00, 1'b1);
    wb(8'hFF, 1'b1);
    m.cond(1'b1, 1'b0);
    wb(8'h21, 1'b1);
    rb(1'b1, 16'h00FF);
    rb(1'b1, 16'h0100);
    rb(1'b0, 16'h0101);
    m.cond(1'b0, 1'b1);
    ptr(16'h0102);
    m.cond(1'b1, 1'b0);
    wb(8'h21, 1'b1);
    rb(1'b0, 16'h0102);
    m.cond(1'b0, 1'b1);
    ptr(16'h0103);
  endtask : t_read
  task automatic t_select();
    sel_en <= 1'b1;
    m.cond(1'b1, 1'b0);
    wb(8'h30, 1'b0);
    m.cond(1'b0, 1'b1);
    sel <= 1'b1;
    m.cond(1'b1, 1'b0);
    wb(8'h20, 1'b0);
    m.cond(1'b1, 1'b0);
    wb(8'h30, 1'b1);
    wb(8'hAB, 1'b1);
    wb(8'hCD, 1'b1);
    m.cond(1'b0, 1'b1);
    ptr(16'hABCD);
    chk("writes", 24'h0, 24'(wq.size()));
    m.cond(1'b1, 1'b0);
    wb(8'h31, 1'b1);
    rb(1'b0, 16'hABCD);
    m.cond(1'b0, 1'b1);
  endtask : t_select
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  initial begin
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    ptr(16'h0000);
    t_write();
    t_read();
    t_select();
    end_sim();
  end
endmodule : two_wire_register_slave_sequencer_test
